// >>> hw/half_bridge_ctrl_diag_regs.sv
// control word decode and diagnosis word assembly behind the serial link
//
// Overview of operation
// R01: enable bit high activates bridge, low floats
// R02: direction bit picks high or low switch
// R03: master sends bit zero low always
// R04: overcurrent sets latched bit 15, bridge off
// R05: overcurrent clears only by clear or reset
// R06: supply fault bit 14 turns all off
// R07: supply fault bit follows supply, self-clearing
// R08: open load sets latched bit 13
// R09: open load shuts bridge only if enabled
// R10: open load clears only by clear or reset
// R11: enable state bits show actual bridge activity
// R12: direction state bits show actual switch state
// R13: bit zero shows live thermal warning
// R14: first word shows only supply, thermal bits
// R15: bit 14 selects group, answer next frame
// R16: bit 15 clears addressed group at deselect
// R17: apply at deselect, capture at select
// R18: reset read address is group zero
// R19: unused diagnosis positions read low
`timescale 1ns/1ns
module half_bridge_ctrl_diag_regs (
   input  wire logic       CORE_CLK_I,          // 10 mhz core clock
   input  wire logic       RST_N_I,             // synchronous reset, active low
   input  wire logic       SCLK_I,              // serial clock pin
   input  wire logic       SELECT_N_I,          // chip select, active low
   input  wire logic       SDI_I,               // serial data in
   output logic            SDO_O,               // serial data out
   output logic            SDO_OE_O,            // drive enable for serial out
   input  wire logic [9:0] OVERCURRENT_I,       // per bridge overcurrent detect
   input  wire logic [9:0] OPEN_LOAD_I,         // per bridge open load detect
   input  wire logic       SUPPLY_FAULT_I,      // load supply out of range
   input  wire logic       THERMAL_WARNING_I,   // junction warning threshold
   output logic [9:0]      HIGH_SIDE_SWITCH_O,  // high-side switch on
   output logic [9:0]      LOW_SIDE_SWITCH_O    // low-side switch on
);
   localparam int LB = hb_regs_pkg::LOW_BRIDGES;
   localparam int HB = hb_regs_pkg::HIGH_BRIDGES;
   localparam int NB = hb_regs_pkg::ALL_BRIDGES;
   localparam int IN_W = 4 + 2 * NB;   // width of the synchronised bundle
   // idle pin levels: clock low, select high, so no false edge follows reset
   localparam logic [IN_W-1:0] SYNC_IDLE = {2'h1, {(IN_W-2){1'h0}}};

   //------------------------------------------------------------
   // two-stage synchronisers for every pin
   //------------------------------------------------------------
   logic [IN_W-1:0] meta;     // first stage, read only by sync
   logic [IN_W-1:0] sync;     // second stage
   logic            sclk_d;   // delayed synced clock for edges
   logic            sel_n_d;  // delayed synced select for edges

   // link and fault pins share one bundle so every bit has equal delay
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         meta    <= SYNC_IDLE;
         sync    <= SYNC_IDLE;
         sclk_d  <= 1'b0;
         sel_n_d <= 1'b1;
      end else begin
         meta    <= {SCLK_I, SELECT_N_I, SDI_I, SUPPLY_FAULT_I,
                     OVERCURRENT_I, OPEN_LOAD_I};
         sync    <= meta;
         sclk_d  <= sync[IN_W-1];
         sel_n_d <= sync[IN_W-2];
      end
   end

   logic       sclk_s;    // synced serial clock
   logic       sel_n_s;   // synced select
   logic       sdi_s;     // synced data in
   logic       psf_s;     // synced supply fault
   logic [9:0] oc_s;      // synced overcurrent
   logic [9:0] ol_s;      // synced open load
   logic       tw_s;      // synced thermal warning
   logic       tw_meta;   // thermal first stage

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         tw_meta <= 1'b0;
         tw_s    <= 1'b0;
      end else begin
         tw_meta <= THERMAL_WARNING_I;
         tw_s    <= tw_meta;
      end
   end

   always_comb begin
      sclk_s  = sync[IN_W-1];
      sel_n_s = sync[IN_W-2];
      sdi_s   = sync[IN_W-3];
      psf_s   = sync[IN_W-4];
      oc_s    = sync[2*NB-1:NB];
      ol_s    = sync[NB-1:0];
   end

   //------------------------------------------------------------
   // link edge detection
   //------------------------------------------------------------
   logic sel_fall;   // frame start
   logic sel_rise;   // frame end
   logic sclk_rise;  // shift out
   logic sclk_fall;  // sample in

   always_comb begin
      sel_fall  = sel_n_d && !sel_n_s;
      sel_rise  = !sel_n_d && sel_n_s;
      sclk_rise = !sel_n_s && !sclk_d && sclk_s;
      sclk_fall = !sel_n_s && sclk_d && !sclk_s;
   end

   //------------------------------------------------------------
   // control registers and frame state
   //------------------------------------------------------------
   hb_regs_pkg::ctrl_word_t bridge_group_low_control;   // group 0 control
   hb_regs_pkg::ctrl_word_t bridge_group_high_control;  // group 1 control
   hb_regs_pkg::ctrl_word_t rx_word;                    // incoming word
   hb_regs_pkg::diag_word_t tx_word;                    // outgoing word
   logic [hb_regs_pkg::CNT_W-1:0] bit_cnt;              // bits received
   logic                          rd_addr;              // group to report
   logic                          first_word;           // nothing sent yet
   logic                          frame_ok;             // full frame seen
   logic                          clr_low;              // clear pulse group 0
   logic                          clr_high;             // clear pulse group 1

   always_comb frame_ok = sel_rise && (bit_cnt == hb_regs_pkg::FRAME_CNT);

   // receive shift, sampled at falling serial clock, msb first
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         rx_word <= hb_regs_pkg::WORD_ZERO;
         bit_cnt <= '0;
      end else if (sel_fall) begin
         bit_cnt <= '0;
      end else if (sclk_fall) begin
         rx_word <= {rx_word[hb_regs_pkg::FRAME_BITS-2:0], sdi_s};
         if (bit_cnt != '1) begin   // counts past 16 so a long frame never applies
            bit_cnt <= bit_cnt + 1'b1;
         end
      end
   end

   // short or long frames are dropped so a torn word never applies
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         bridge_group_low_control  <= hb_regs_pkg::WORD_ZERO;
         bridge_group_high_control <= hb_regs_pkg::WORD_ZERO;
         rd_addr                   <= hb_regs_pkg::ADDR_RESET;   // [R18]
      end else if (frame_ok) begin
         rd_addr <= rx_word.addr;                                 // [R15]
         if (rx_word.addr == hb_regs_pkg::ADDR_LOW) begin         // [R15] [R17]
            bridge_group_low_control <= rx_word;
         end else begin
            bridge_group_high_control <= rx_word;
         end
      end
   end

   // status clear acts only on the addressed group, one cycle long
   always_comb begin
      clr_low  = frame_ok && rx_word.status_clear_cmd
                 && (rx_word.addr == hb_regs_pkg::ADDR_LOW);       // [R16]
      clr_high = frame_ok && rx_word.status_clear_cmd
                 && (rx_word.addr == hb_regs_pkg::ADDR_HIGH);      // [R16]
   end

   //------------------------------------------------------------
   // bridge groups
   //------------------------------------------------------------
   logic          oc_lo, ol_lo, oc_hi, ol_hi;  // group flags
   logic [LB-1:0] act_lo, hs_lo, ls_lo;        // group 0 state
   logic [HB-1:0] act_hi, hs_hi, ls_hi;        // group 1 state

   hb_group #(.N(LB)) u_group_low (
      .clk_i        (CORE_CLK_I),
      .rst_n_i      (RST_N_I),
      .enable_i     (bridge_group_low_control.bridge_enable),      // [R01]
      .direction_i  (bridge_group_low_control.bridge_direction),   // [R02]
      .open_load_shutdown_enable_i   (bridge_group_low_control.open_load_shutdown_enable),
      .clear_i      (clr_low),
      .oc_evt_i     (oc_s[LB-1:0]),
      .ol_evt_i     (ol_s[LB-1:0]),
      .supply_bad_i (psf_s),
      .oc_flag_o    (oc_lo),
      .ol_flag_o    (ol_lo),
      .active_o     (act_lo),
      .high_side_o  (hs_lo),
      .low_side_o   (ls_lo)
   );

   // don't-care control bits 12, 11, 6, 5 and bit 0 never reach logic
   hb_group #(.N(HB)) u_group_high (
      .clk_i        (CORE_CLK_I),
      .rst_n_i      (RST_N_I),
      .enable_i     (bridge_group_high_control.bridge_enable[HB-1:0]),    // [R03]
      .direction_i  (bridge_group_high_control.bridge_direction[HB-1:0]),
      .open_load_shutdown_enable_i   (bridge_group_high_control.open_load_shutdown_enable),
      .clear_i      (clr_high),
      .oc_evt_i     (oc_s[NB-1:LB]),
      .ol_evt_i     (ol_s[NB-1:LB]),
      .supply_bad_i (psf_s),
      .oc_flag_o    (oc_hi),
      .ol_flag_o    (ol_hi),
      .active_o     (act_hi),
      .high_side_o  (hs_hi),
      .low_side_o   (ls_hi)
   );

   always_comb begin
      HIGH_SIDE_SWITCH_O = {hs_hi, hs_lo};
      LOW_SIDE_SWITCH_O  = {ls_hi, ls_lo};
   end

   //------------------------------------------------------------
   // diagnosis assembly and transmit shift
   //------------------------------------------------------------
   hb_regs_pkg::diag_word_t diag_now;  // word for the current read address

   // state bits come from the driver stage; group 0 direction gates its control register with act_lo
   always_comb begin
      diag_now = hb_regs_pkg::WORD_ZERO;                          // [R19]
      diag_now.supply_fault_flag    = psf_s;                      // [R06] [R07]
      diag_now.thermal_warning_flag = tw_s;                       // [R13]
      if (rd_addr == hb_regs_pkg::ADDR_LOW) begin
         diag_now.overcurrent_flag       = oc_lo;
         diag_now.open_load_flag         = ol_lo;
         diag_now.bridge_enable_state    = act_lo;                // [R11]
         diag_now.bridge_direction_state = act_lo & bridge_group_low_control.bridge_direction; // [R12]
      end else begin
         diag_now.overcurrent_flag                = oc_hi;
         diag_now.open_load_flag                  = ol_hi;
         diag_now.bridge_enable_state[HB-1:0]     = act_hi;       // [R11]
         diag_now.bridge_direction_state[HB-1:0]  = hs_hi;        // [R12]
      end
      if (first_word) begin
         diag_now.overcurrent_flag       = 1'b0;                  // [R14]
         diag_now.open_load_flag         = 1'b0;
         diag_now.bridge_enable_state    = '0;
         diag_now.bridge_direction_state = '0;
      end
   end

   // capture at frame start, shift on rising serial clock
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         tx_word    <= hb_regs_pkg::WORD_ZERO;
         first_word <= 1'b1;
      end else if (sel_fall) begin
         tx_word    <= diag_now;                                  // [R17]
         first_word <= 1'b0;
      end else if (sclk_rise) begin
         tx_word <= {tx_word[hb_regs_pkg::FRAME_BITS-2:0], 1'b0};
      end
   end

   always_comb begin
      SDO_O    = tx_word[hb_regs_pkg::FRAME_BITS-1];
      SDO_OE_O = !sel_n_s;
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   sequence s_full_frame_end;
      frame_ok;
   endsequence

   a_apply_low_word: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R17]
      s_full_frame_end ##0 !rx_word.addr |=> bridge_group_low_control == $past(rx_word))
      else $error("group 0 control not applied at deselect");
   a_ctrl_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R17]
      !frame_ok |=> $stable(bridge_group_low_control) && $stable(bridge_group_high_control))
      else $error("control word changed outside a frame end");
   a_clear_target: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R16]
      (clr_low || clr_high) |-> rx_word.status_clear_cmd && !(clr_low && clr_high))
      else $error("status clear without command or on both groups");
   a_capture_word: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R17]
      sel_fall |=> tx_word == $past(diag_now))
      else $error("diagnosis not captured at select");
   a_first_mask: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R14]
      sel_fall && first_word |=> (tx_word[15] == 1'b0) && (tx_word[13:1] == '0))
      else $error("first diagnosis word carries stale bits");
   a_psf_live: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R07]
      diag_now.supply_fault_flag == psf_s)
      else $error("supply fault bit not following supply");
   a_dont_care_low: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R19]
      rd_addr |-> (diag_now[12:11] == '0) && (diag_now[6:5] == '0))
      else $error("unused diagnosis bits of group 1 not low");
   a_addr_follow: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R15]
      s_full_frame_end |=> rd_addr == $past(rx_word.addr))
      else $error("read address not taken from frame");
endmodule // half_bridge_ctrl_diag_regs

// >>> hw/hb_regs_pkg.sv
// constants and carrier types for the half-bridge control and diagnosis words
package hb_regs_pkg;
   //------------------------------------------------------------
   // frame and group sizes
   //------------------------------------------------------------
   localparam int         FRAME_BITS   = 16;      // one spi word
   localparam int         CNT_W        = 5;       // bit counter width
   localparam logic [4:0] FRAME_CNT    = 5'h10;   // full frame bit count
   localparam int         LOW_BRIDGES  = 6;       // bridges 1..6
   localparam int         HIGH_BRIDGES = 4;       // bridges 7..10
   localparam int         ALL_BRIDGES  = 10;      // total outputs
   localparam int         FIELD_W      = 6;       // enable/direction field width
   localparam logic       ADDR_LOW     = 1'h0;    // group of bridges 1..6
   localparam logic       ADDR_HIGH    = 1'h1;    // group of bridges 7..10
   localparam logic       ADDR_RESET   = 1'h0;    // read address after reset
   localparam logic [15:0] WORD_ZERO   = 16'h0000; // reset value of all words

   //------------------------------------------------------------
   // word layouts, bit 15 first
   //------------------------------------------------------------
   typedef struct packed {
      logic               status_clear_cmd;          // 15
      logic               addr;                      // 14
      logic               open_load_shutdown_enable; // 13
      logic [FIELD_W-1:0] bridge_enable;             // 12..7
      logic [FIELD_W-1:0] bridge_direction;          // 6..1
      logic               zero;                      // 0
   } ctrl_word_t;

   typedef struct packed {
      logic               overcurrent_flag;       // 15
      logic               supply_fault_flag;      // 14
      logic               open_load_flag;         // 13
      logic [FIELD_W-1:0] bridge_enable_state;    // 12..7
      logic [FIELD_W-1:0] bridge_direction_state; // 6..1
      logic               thermal_warning_flag;   // 0
   } diag_word_t;
endpackage

// >>> hw/hb_group.sv
// one bridge group: fault latching, output gating and actual state
`timescale 1ns/1ns
module hb_group #(
   parameter int N = 6
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [N-1:0] enable_i,     // written bridge enables
   input  wire logic [N-1:0] direction_i,  // written bridge directions
   input  wire logic         open_load_shutdown_enable_i,   // open-load shutdown enable
   input  wire logic         clear_i,      // status clear pulse
   input  wire logic [N-1:0] oc_evt_i,     // synced overcurrent per bridge
   input  wire logic [N-1:0] ol_evt_i,     // synced open load per bridge
   input  wire logic         supply_bad_i, // synced supply fault level
   output logic              oc_flag_o,    // latched group overcurrent
   output logic              ol_flag_o,    // latched group open load
   output logic [N-1:0]      active_o,     // actual active state
   output logic [N-1:0]      high_side_o,  // high-side switch on
   output logic [N-1:0]      low_side_o    // low-side switch on
);
   //------------------------------------------------------------
   // latched per-bridge shutdown state
   //------------------------------------------------------------
   logic [N-1:0] oc_off;  // bridge off after overcurrent
   logic [N-1:0] ol_off;  // bridge off after open load

   // set wins over a clear landing in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         oc_off    <= '0;
         ol_off    <= '0;
         oc_flag_o <= 1'b0;
         ol_flag_o <= 1'b0;
      end else begin
         oc_off    <= (oc_off & {N{!clear_i}}) | oc_evt_i;              // [R04] [R05]
         ol_off    <= (ol_off & {N{!clear_i}}) | (ol_evt_i & {N{open_load_shutdown_enable_i}}); // [R09]
         oc_flag_o <= (oc_flag_o & !clear_i) | (|oc_evt_i);             // [R04] [R05]
         ol_flag_o <= (ol_flag_o & !clear_i) | (|ol_evt_i);             // [R08] [R10]
      end
   end

   //------------------------------------------------------------
   // output stage, supply fault forces every bridge off
   //------------------------------------------------------------
   always_comb begin
      active_o    = enable_i & ~oc_off & ~ol_off & {N{!supply_bad_i}}; // [R01] [R06]
      high_side_o = active_o & direction_i;                            // [R02]
      low_side_o  = active_o & ~direction_i;                           // [R02]
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   sequence s_oc_hit;
      |oc_evt_i;
   endsequence

   a_oc_latch_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04]
      s_oc_hit |=> oc_flag_o && ((oc_off & active_o) == '0))
      else $error("overcurrent not latched or bridge left on");
   a_oc_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R05]
      oc_flag_o && !clear_i |=> oc_flag_o)
      else $error("overcurrent flag dropped without clear");
   a_ol_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
      ol_flag_o && !clear_i |=> ol_flag_o)
      else $error("open load flag dropped without clear");
   a_ol_stays_on: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R09]
      !open_load_shutdown_enable_i && (ol_off == '0) |=> ol_off == '0)
      else $error("open load shut a bridge with shutdown disabled");
   a_supply_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
      supply_bad_i |-> (high_side_o == '0) && (low_side_o == '0))
      else $error("output on during supply fault");
endmodule // hb_group

// >>> test/hb_spi_master.sv
// serial master model that frames control words into the half-bridge block
`timescale 1ns/1ns
module hb_spi_master (
   input  wire logic clk_i,      // core clock, paces every pin change
   input  wire logic sdo_i,      // serial out of the block
   input  wire logic sdo_oe_i,   // block drives serial out
   output logic      sclk_o,     // serial clock, still between frames
   output logic      select_n_o, // chip select, active low
   output logic      sdi_o       // serial data into the block
);
   logic sdo_last = 1'b0;        // last driven level on serial out
   logic sdo_line;               // resolved serial out wire

   //----------------------------------------------------------
   // released line shows the inverse, so a stale bit never passes
   //----------------------------------------------------------
   assign sdo_line = sdo_oe_i ? sdo_i : ~sdo_last;
   always_ff @(posedge clk_i) begin
      if (sdo_oe_i) begin
         sdo_last <= sdo_i;
      end
   end

   initial begin
      sclk_o     = 1'b0;
      select_n_o = 1'b1;
      sdi_o      = 1'b0;
   end

   //----------------------------------------------------------
   // one frame, msb first; short frames test refusal
   //----------------------------------------------------------
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk_i) select_n_o <= 1'b0; // clock low at select edges
      repeat (8) @(posedge clk_i);
      for (int i = 15; i > 15 - nbits; i--) begin
         rx[i[3:0]] = sdo_line;            // settled bit, before the rise
         sdi_o  <= tx[i[3:0]];             // bit 0 arrives low from caller
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;                   // block samples after this fall
         repeat (4) @(posedge clk_i);
      end
      select_n_o <= 1'b1;                  // word applied here
      sdi_o      <= ~sdi_o;                // no lingering data on the line
      repeat (8) @(posedge clk_i);         // gap covers apply latency
   endtask
endmodule // hb_spi_master

// >>> test/half_bridge_ctrl_diag_regs_tb.sv
// self-checking bench for control decode and diagnosis assembly
`timescale 1ns/1ns
module half_bridge_ctrl_diag_regs_tb;
   logic       CORE_CLK_I;        // 10 mhz core clock
   logic       RST_N_I;           // synchronous reset, active low
   logic       SCLK_I;            // serial clock from the master model
   logic       SELECT_N_I;        // chip select from the master model
   logic       SDI_I;             // serial data from the master model
   logic       SDO_O;             // serial data out
   logic       SDO_OE_O;          // serial out drive enable
   logic [9:0] OVERCURRENT_I;     // per bridge overcurrent detect
   logic [9:0] OPEN_LOAD_I;       // per bridge open load detect
   logic       SUPPLY_FAULT_I;    // load supply out of range
   logic       THERMAL_WARNING_I; // junction warning
   logic [9:0] HIGH_SIDE_SWITCH_O; // high-side switches
   logic [9:0] LOW_SIDE_SWITCH_O;  // low-side switches
   int         mismatches = 0;    // failed comparisons
   int         checked    = 0;    // all comparisons

   half_bridge_ctrl_diag_regs dut_u (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
      .SCLK_I(SCLK_I), .SELECT_N_I(SELECT_N_I), .SDI_I(SDI_I), .SDO_O(SDO_O),
      .SDO_OE_O(SDO_OE_O), .OVERCURRENT_I(OVERCURRENT_I), .OPEN_LOAD_I(OPEN_LOAD_I),
      .SUPPLY_FAULT_I(SUPPLY_FAULT_I), .THERMAL_WARNING_I(THERMAL_WARNING_I),
      .HIGH_SIDE_SWITCH_O(HIGH_SIDE_SWITCH_O), .LOW_SIDE_SWITCH_O(LOW_SIDE_SWITCH_O));

   hb_spi_master master_u (.clk_i(CORE_CLK_I), .sdo_i(SDO_O), .sdo_oe_i(SDO_OE_O),
      .sclk_o(SCLK_I), .select_n_o(SELECT_N_I), .sdi_o(SDI_I));

   //----------------------------------------------------------
   // word builders; group 1 sets its ignored positions high on purpose
   //----------------------------------------------------------
   function automatic hb_regs_pkg::ctrl_word_t w0(input logic c, input logic s,
                                                   input logic [5:0] e, input logic [5:0] d);
      return {c, 1'h0, s, e, d, 1'h0};
   endfunction
   function automatic hb_regs_pkg::ctrl_word_t w1(input logic c, input logic s,
                                                   input logic [3:0] e, input logic [3:0] d);
      return {c, 1'h1, s, 2'h3, e, 2'h3, d, 1'h0};
   endfunction
   function automatic hb_regs_pkg::diag_word_t d0(input logic [2:0] f, input logic [5:0] e,
                                                   input logic [5:0] d, input logic t);
      return {f, e, d, t};
   endfunction
   function automatic hb_regs_pkg::diag_word_t d1(input logic [2:0] f, input logic [3:0] e,
                                                   input logic [3:0] d, input logic t);
      return {f, 2'h0, e, 2'h0, d, t};
   endfunction

   //----------------------------------------------------------
   // comparison, frame and fault helpers
   //----------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xfer(input logic [15:0] tx, input logic [15:0] exp);
      logic [15:0] rx;
      master_u.frame(tx, 16, rx);
      chk("diagnosis word", rx, exp);
   endtask
   task automatic sw(input logic [9:0] hs, input logic [9:0] ls);
      chk("high side", {6'h00, HIGH_SIDE_SWITCH_O}, {6'h00, hs});
      chk("low side", {6'h00, LOW_SIDE_SWITCH_O}, {6'h00, ls});
   endtask
   // fault pulse of three clocks, then time for sync and latch
   task automatic pulse(input logic [9:0] oc, input logic [9:0] ol);
      OVERCURRENT_I <= oc;
      OPEN_LOAD_I   <= ol;
      repeat (3) @(posedge CORE_CLK_I);
      OVERCURRENT_I <= 10'h000;
      OPEN_LOAD_I   <= 10'h000;
      repeat (6) @(posedge CORE_CLK_I);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      CORE_CLK_I = 1'b0;
      forever #50 CORE_CLK_I = ~CORE_CLK_I;
   end

   // watchdog, in case the link stops answering
   initial begin
      repeat (60000) @(posedge CORE_CLK_I);
      mismatches++;
      stop_test();
   end

   //----------------------------------------------------------
   // main sequence
   //----------------------------------------------------------
   initial begin
      logic [15:0] junk;
      RST_N_I = 1'b0;
      OVERCURRENT_I = 10'h000;
      OPEN_LOAD_I = 10'h000;
      SUPPLY_FAULT_I = 1'b0;
      THERMAL_WARNING_I = 1'b1;
      repeat (6) @(posedge CORE_CLK_I);
      RST_N_I <= 1'b1;
      repeat (5) @(posedge CORE_CLK_I);
      chk("drive enable", {15'h0000, SDO_OE_O}, 16'h0000);
      xfer(w0(0, 0, 6'h3F, 6'h2A), 16'h0001);
      sw(10'h02A, 10'h015);
      xfer(w1(0, 0, 4'hF, 4'h3), d0(3'h0, 6'h3F, 6'h2A, 1));
      sw(10'h0EA, 10'h315);
      master_u.frame(w0(0, 0, 6'h00, 6'h00), 15, junk);          // short frame is ignored
      sw(10'h0EA, 10'h315);
      master_u.frame(w0(0, 0, 6'h00, 6'h00), 17, junk);          // long frame is ignored
      sw(10'h0EA, 10'h315);
      xfer(w1(0, 0, 4'hF, 4'h3), d1(3'h0, 4'hF, 4'h3, 1));
      // overcurrent on bridge 7 latches and turns it off
      pulse(10'h040, 10'h000);
      sw(10'h0AA, 10'h315);
      xfer(w1(0, 0, 4'hF, 4'h3), d1(3'h4, 4'hE, 4'h2, 1));
      xfer(w1(1, 0, 4'hF, 4'h3), d1(3'h4, 4'hE, 4'h2, 1));
      xfer(w1(0, 0, 4'hF, 4'h3), d1(3'h0, 4'hF, 4'h3, 1));
      // open load on bridge 1, shutdown disabled then enabled
      pulse(10'h000, 10'h001);
      sw(10'h0EA, 10'h315);
      xfer(w0(0, 1, 6'h3F, 6'h2A), d1(3'h0, 4'hF, 4'h3, 1));
      xfer(w0(0, 1, 6'h3F, 6'h2A), d0(3'h1, 6'h3F, 6'h2A, 1));
      pulse(10'h000, 10'h001);
      sw(10'h0EA, 10'h314);
      xfer(w0(1, 1, 6'h3F, 6'h2A), d0(3'h1, 6'h3E, 6'h2A, 1));
      xfer(w0(0, 0, 6'h3F, 6'h2A), d0(3'h0, 6'h3F, 6'h2A, 1));
      // supply fault turns all off and clears by itself
      SUPPLY_FAULT_I <= 1'b1;
      repeat (5) @(posedge CORE_CLK_I);
      sw(10'h000, 10'h000);
      xfer(w0(0, 0, 6'h3F, 6'h2A), d0(3'h2, 6'h00, 6'h00, 1));
      SUPPLY_FAULT_I <= 1'b0;
      THERMAL_WARNING_I <= 1'b0;
      repeat (5) @(posedge CORE_CLK_I);
      xfer(w0(0, 0, 6'h3F, 6'h2A), d0(3'h0, 6'h3F, 6'h2A, 0));
      sw(10'h0EA, 10'h315);
      stop_test();
   end
endmodule // half_bridge_ctrl_diag_regs_tb
